//--- verilog/aid_pkg.sv
// Constants, record layout and carrier types of the analog input diagnostic record.
// Assumes one 250 MHz core clock and a synchronous, active-high reset.
`default_nettype none

package aid_pkg;

  // ==========================================================================
  // Clock and ticker timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 4;          // core_clk period
  localparam int unsigned TICK_PERIOD_NS = 1000;      // one microsecond
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam logic [31:0] TICKER_RESET = 32'h0000_0000;

  // ==========================================================================
  // Record byte offsets, in the order the record is read out
  // ==========================================================================
  localparam logic [4:0] OFS_MODULE_DIAG_FIRST = 5'h00;
  localparam logic [4:0] OFS_MODULE_INFO = 5'h01;
  localparam logic [4:0] OFS_MODULE_DIAG_RSVD = 5'h02;
  localparam logic [4:0] OFS_MODULE_DIAG_SECOND = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_TYPE = 5'h04;
  localparam logic [4:0] OFS_DIAG_BITS_PER_CHANNEL = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_CHANNEL_SUMMARY = 5'h07;
  localparam logic [4:0] OFS_CHAN0_ERROR = 5'h08;
  localparam logic [4:0] OFS_UPPER_CHAN_ERROR_RESERVED = 5'h0C;
  localparam logic [4:0] OFS_DIAG_TIMESTAMP = 5'h10;
  localparam logic [4:0] OFS_LAST = 5'h13;

  // ==========================================================================
  // Field positions and fixed values
  // ==========================================================================
  localparam int unsigned FIRST_CHAN_ERR_BIT = 3;
  localparam int unsigned FIRST_PARAM_ERR_BIT = 7;
  localparam int unsigned SECOND_BUF_OVF_BIT = 3;
  localparam int unsigned SECOND_COMM_ERR_BIT = 4;
  localparam int unsigned CHAN_PARAM_ERR_BIT = 0;
  localparam int unsigned CHAN_UNDERFLOW_BIT = 6;
  localparam int unsigned CHAN_OVERFLOW_BIT = 7;
  localparam logic [7:0] MODULE_INFO_VALUE = 8'h15;
  localparam logic [7:0] CHANNEL_TYPE_VALUE = 8'h71;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL_VALUE = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h04;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int unsigned NUM_CHANNELS = 4;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic overflow;   // Value above measuring range
    logic underflow;  // Value below measuring range
    logic param_err;  // Configuration or parameter error
  } aid_chan_status_t;

  typedef struct packed {
    logic       rd_en;
    logic [4:0] rd_index;
  } aid_rd_req_t;

endpackage : aid_pkg

`default_nettype wire

//--- verilog/aid_us_ticker.sv
// Free-running microsecond ticker with its own prescaler.
// Assumes core_clk at the rate given in aid_pkg and a synchronous reset at power-on.
`default_nettype none

module aid_us_ticker (
  input  wire logic        core_clk,
  input  wire logic        reset,
  output logic             us_pulse,
  output logic [31:0]      us_count
);

  // ==========================================================================
  // Prescaler
  // ==========================================================================
  logic [7:0] presc_reg;

  // Counts core cycles up to one microsecond enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      presc_reg <= 8'h00;
    end else if (presc_reg == aid_pkg::TICK_LAST) begin
      presc_reg <= 8'h00;
    end else begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  // Enable pulse is registered so the counter and the pulse line up
  always_ff @(posedge core_clk) begin
    if (reset) begin
      us_pulse <= 1'b0;
    end else begin
      us_pulse <= (presc_reg == aid_pkg::TICK_LAST);
    end
  end

  // ==========================================================================
  // Microsecond counter
  // ==========================================================================
  // Wraps by plain 32-bit overflow, no saturation
  always_ff @(posedge core_clk) begin
    if (reset) begin
      us_count <= aid_pkg::TICKER_RESET;
    end else if (presc_reg == aid_pkg::TICK_LAST) begin
      us_count <= us_count + 32'h0000_0001;
    end
  end

endmodule : aid_us_ticker

`default_nettype wire

//--- verilog/aid_diag_record.sv
// Read-only diagnostic record of a four-channel analog input module.
// Assumes condition inputs come from logic on core_clk and the reader issues byte reads.
`default_nettype none

// Overview of operation
// - Second module byte bit 3 shows diagnostics buffer overflow; other low/high bits zero.
// - Second module byte bit 4 shows internal communication error.
// - Bits-per-channel descriptor always reads 08h.
// - Channel-count descriptor always reads 04h.
// - Channel byte bit 0 shows parameter error; bits 5 to 1 read zero.
// - Channel byte bit 6 shows measured value below range.
// - Channel byte bit 7 shows measured value above range.
// - A new diagnostic latches the current microsecond ticker into the timestamp.
// - The microsecond ticker starts at zero after power-on reset.
// - The ticker wraps from all ones back to zero and keeps counting.
// - First module byte bit 3 shows that some channel has an error.
// - Channel errors light the channel indicator and enter the record; no interrupt.
module aid_diag_record (
  input  wire logic                                core_clk,
  input  wire logic                                reset,
  input  wire logic                                diag_buf_overflow,
  input  wire logic                                comm_error,
  input  wire aid_pkg::aid_chan_status_t [3:0]     chan_status,
  input  wire aid_pkg::aid_rd_req_t                rd_req,
  output logic                                     rd_valid,
  output logic [7:0]                               rd_data,
  output logic [3:0]                               chan_led,
  output logic                                     module_err_led
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic        us_pulse;
  logic [31:0] us_count;
  logic [7:0]  module_diag_first_reg;
  logic [7:0]  module_diag_first_next;
  logic [7:0]  module_diag_second_reg;
  logic [7:0]  module_diag_second_next;
  logic [7:0]  chan_summary_reg;
  logic [7:0]  chan_summary_next;
  logic [7:0]  chan_error_reg [4];
  logic [7:0]  chan_error_next [4];
  logic [31:0] diag_timestamp_reg;
  logic        new_diag;
  logic [7:0]  rd_byte;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Packs one channel's conditions into its error byte, reserved bits zero
  function automatic logic [7:0] aid_chan_byte(input aid_pkg::aid_chan_status_t s);
    logic [7:0] b;
    b = 8'h00;
    b[aid_pkg::CHAN_PARAM_ERR_BIT] = s.param_err;
    b[aid_pkg::CHAN_UNDERFLOW_BIT] = s.underflow;
    b[aid_pkg::CHAN_OVERFLOW_BIT] = s.overflow;
    return b;
  endfunction : aid_chan_byte

  // Picks one byte of a 32-bit word, byte 0 the least significant
  function automatic logic [7:0] aid_word_byte(input logic [31:0] w, input logic [1:0] sel);
    logic [7:0] b;
    b = w[8*sel +: 8];
    return b;
  endfunction : aid_word_byte

  // ==========================================================================
  // Microsecond ticker
  // ==========================================================================
  aid_us_ticker u_ticker (
    .core_clk (core_clk),
    .reset    (reset),
    .us_pulse (us_pulse),
    .us_count (us_count)
  );

  // ==========================================================================
  // Next values of the record bytes
  // ==========================================================================
  // Bytes track the present condition; a cleared cause clears the bit next cycle
  always_comb begin
    module_diag_second_next = 8'h00;
    module_diag_second_next[aid_pkg::SECOND_BUF_OVF_BIT] = diag_buf_overflow;
    module_diag_second_next[aid_pkg::SECOND_COMM_ERR_BIT] = comm_error;
    chan_summary_next = 8'h00;
    module_diag_first_next = 8'h00;
    for (int i = 0; i < aid_pkg::NUM_CHANNELS; i++) begin
      chan_error_next[i] = aid_chan_byte(chan_status[i]);
      chan_summary_next[i] = |chan_error_next[i];
      if (chan_status[i].param_err) begin
        module_diag_first_next[aid_pkg::FIRST_PARAM_ERR_BIT] = 1'b1;
      end
    end
    module_diag_first_next[aid_pkg::FIRST_CHAN_ERR_BIT] = |chan_summary_next;
  end

  // A diagnostic is new when any bit rises that was clear the cycle before
  always_comb begin
    new_diag = |(module_diag_second_next & ~module_diag_second_reg);
    for (int i = 0; i < aid_pkg::NUM_CHANNELS; i++) begin
      if (|(chan_error_next[i] & ~chan_error_reg[i])) begin
        new_diag = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Record registers
  // ==========================================================================
  // Module-level bytes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      module_diag_first_reg <= aid_pkg::BYTE_RESET;
      module_diag_second_reg <= aid_pkg::BYTE_RESET;
      chan_summary_reg <= aid_pkg::BYTE_RESET;
    end else begin
      module_diag_first_reg <= module_diag_first_next;
      module_diag_second_reg <= module_diag_second_next;
      chan_summary_reg <= chan_summary_next;
    end
  end

  // Per-channel error bytes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < aid_pkg::NUM_CHANNELS; i++) begin
        chan_error_reg[i] <= aid_pkg::BYTE_RESET;
      end
    end else begin
      for (int i = 0; i < aid_pkg::NUM_CHANNELS; i++) begin
        chan_error_reg[i] <= chan_error_next[i];
      end
    end
  end

  // Timestamp holds until the next new diagnostic; a reader may see it change
  // between byte reads if a diagnostic arrives mid-record
  always_ff @(posedge core_clk) begin
    if (reset) begin
      diag_timestamp_reg <= aid_pkg::TICKER_RESET;
    end else if (new_diag) begin
      diag_timestamp_reg <= us_count;
    end
  end

  // ==========================================================================
  // Indicators
  // ==========================================================================
  // Channel indicators follow the channel bytes; there is no interrupt output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      chan_led <= 4'h0;
      module_err_led <= 1'b0;
    end else begin
      chan_led <= chan_summary_next[3:0];
      module_err_led <= (|chan_summary_next) | (|module_diag_second_next);
    end
  end

  // ==========================================================================
  // Record read port
  // ==========================================================================
  // Unmapped and reserved offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_req.rd_index) inside
      aid_pkg::OFS_MODULE_DIAG_FIRST: rd_byte = module_diag_first_reg;
      aid_pkg::OFS_MODULE_INFO: rd_byte = aid_pkg::MODULE_INFO_VALUE;
      aid_pkg::OFS_MODULE_DIAG_SECOND: rd_byte = module_diag_second_reg;
      aid_pkg::OFS_CHANNEL_TYPE: rd_byte = aid_pkg::CHANNEL_TYPE_VALUE;
      aid_pkg::OFS_DIAG_BITS_PER_CHANNEL: rd_byte = aid_pkg::DIAG_BITS_PER_CHANNEL_VALUE;
      aid_pkg::OFS_CHANNEL_COUNT: rd_byte = aid_pkg::CHANNEL_COUNT_VALUE;
      aid_pkg::OFS_CHANNEL_SUMMARY: rd_byte = chan_summary_reg;
      [aid_pkg::OFS_CHAN0_ERROR : aid_pkg::OFS_UPPER_CHAN_ERROR_RESERVED - 5'h01]: begin
        rd_byte = chan_error_reg[rd_req.rd_index[1:0]];
      end
      [aid_pkg::OFS_DIAG_TIMESTAMP : aid_pkg::OFS_LAST]: begin
        rd_byte = aid_word_byte(diag_timestamp_reg, rd_req.rd_index[1:0]);
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Answer one cycle after the request, data held until the next read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= rd_req.rd_en;
      if (rd_req.rd_en) begin
        rd_data <= rd_byte;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_buf_overflow_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    diag_buf_overflow |=> module_diag_second_reg[3] && (module_diag_second_reg & 8'hE7) == 8'h00)
    else $error("buffer overflow bit not set or reserved bits nonzero");

  a_comm_error_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    comm_error ##1 (rd_req.rd_en && rd_req.rd_index == 5'h03 && $past(comm_error)) |=> rd_data[4])
    else $error("communication error bit not read back");

  a_bits_descriptor: assert property (
    @(posedge core_clk) disable iff (reset)
    (rd_req.rd_en && rd_req.rd_index == 5'h05) |=> rd_valid && rd_data == 8'h08)
    else $error("bits per channel descriptor wrong");

  a_count_descriptor: assert property (
    @(posedge core_clk) disable iff (reset)
    (rd_req.rd_en && rd_req.rd_index == 5'h06) |=> rd_valid && rd_data == 8'h04)
    else $error("channel count descriptor wrong");

  for (genvar g = 0; g < 4; g++) begin : g_chan_chk
    a_chan_param_bit: assert property (
      @(posedge core_clk) disable iff (reset)
      ##1 chan_error_reg[g][0] == $past(chan_status[g].param_err) && chan_error_reg[g][5:1] == 5'h00)
      else $error("channel parameter bit mismatch");
    a_chan_under_bit: assert property (
      @(posedge core_clk) disable iff (reset)
      chan_status[g].underflow |=> chan_error_reg[g][6] && chan_led[g])
      else $error("channel underflow bit or indicator missing");
    a_chan_over_bit: assert property (
      @(posedge core_clk) disable iff (reset)
      $rose(chan_status[g].overflow) |=> chan_error_reg[g][7] && diag_timestamp_reg == $past(us_count))
      else $error("channel overflow bit or timestamp missing");
  end

  a_stamp_capture: assert property (
    @(posedge core_clk) disable iff (reset)
    !new_diag |=> $stable(diag_timestamp_reg))
    else $error("timestamp changed without a new diagnostic");

  a_ticker_start: assert property (
    @(posedge core_clk) $fell(reset) |-> us_count == 32'h0000_0000)
    else $error("ticker not zero after reset");

  a_ticker_step: assert property (
    @(posedge core_clk) disable iff (reset)
    us_pulse |-> us_count == $past(us_count) + 32'h0000_0001)
    else $error("ticker did not advance by one");

  a_pulse_spacing: assert property (
    @(posedge core_clk) disable iff (reset)
    us_pulse |=> !us_pulse [*8] ##242 us_pulse)
    else $error("microsecond pulse spacing wrong");

  a_chan_summary: assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 module_diag_first_reg[3] == (|{chan_error_reg[3], chan_error_reg[2], chan_error_reg[1], chan_error_reg[0]}))
    else $error("channel error summary bit mismatch");

  a_led_follow: assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 chan_led == {|chan_error_reg[3], |chan_error_reg[2], |chan_error_reg[1], |chan_error_reg[0]})
    else $error("channel indicator does not follow record");

  a_module_led: assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 module_err_led == ((|chan_summary_reg[3:0]) | (|module_diag_second_reg)))
    else $error("module error indicator does not follow record");

  a_stamp_load: assert property (
    @(posedge core_clk) disable iff (reset)
    new_diag |=> diag_timestamp_reg == $past(us_count))
    else $error("timestamp not loaded on a new diagnostic");

  a_rd_answer: assert property (
    @(posedge core_clk) disable iff (reset)
    rd_req.rd_en |=> rd_valid)
    else $error("record read not answered in the next cycle");

  a_rd_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    !rd_req.rd_en |=> !rd_valid && $stable(rd_data))
    else $error("read answer appeared or changed without a request");

  // Cycles since the last microsecond pulse; checks only, the first pulse after reset is skipped
  logic [7:0] pulse_gap_reg;
  logic       pulse_seen_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulse_gap_reg <= 8'h00;
      pulse_seen_reg <= 1'b0;
    end else if (us_pulse) begin
      pulse_gap_reg <= 8'h00;
      pulse_seen_reg <= 1'b1;
    end else if (pulse_gap_reg != 8'hFF) begin
      pulse_gap_reg <= pulse_gap_reg + 8'h01; // Saturates so it never wraps back into range
    end
  end

  a_pulse_gap: assert property (
    @(posedge core_clk) disable iff (reset)
    (us_pulse && pulse_seen_reg) |-> pulse_gap_reg == aid_pkg::TICK_LAST)
    else $error("microsecond pulses not one microsecond apart");

endmodule : aid_diag_record

`default_nettype wire

//--- testbench/aid_reader_model.sv
// Reader model of the backplane coupler that fetches the diagnostic record byte by byte.
// Assumes core_clk from the bench; requests change 1 ns after a rising edge.
`default_nettype none

module aid_reader_model (
  input  wire logic                core_clk,
  output var  aid_pkg::aid_rd_req_t rd_req,
  input  wire logic                rd_valid,
  input  wire logic [7:0]          rd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial rd_req = '0;

  // ==========================================================================
  // Byte read
  // ==========================================================================
  // Strobe held through the taking edge, answer taken once it has settled.
  // The released index is inverted so a design that keeps using it is caught.
  task automatic read_byte(input logic [4:0] idx, input int gap, output logic [7:0] data, output logic valid);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    #1 rd_req = '{rd_en: 1'b1, rd_index: idx};
    @(posedge core_clk);
    #1 rd_req = '{rd_en: 1'b0, rd_index: ~idx};
    valid = rd_valid;
    data = rd_data;
  endtask : read_byte

endmodule : aid_reader_model

`default_nettype wire

//--- testbench/analog_input_diag_record_test.sv
// Self-checking bench of the diagnostic record: reads bytes through the reader model.
// Assumes the design package is compiled first; ticker wrap is too long to reach here.
`default_nettype none

module analog_input_diag_record_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TICKS = 250; // Core cycles per microsecond

  logic                            core_clk = 1'b0;
  logic                            reset = 1'b1;
  logic                            diag_buf_overflow = 1'b0;
  logic                            comm_error = 1'b0;
  aid_pkg::aid_chan_status_t [3:0] chan_status = '0;
  aid_pkg::aid_rd_req_t            rd_req;
  logic                            rd_valid;
  logic [7:0]                      rd_data;
  logic [3:0]                      chan_led;
  logic                            module_err_led;
  int                              n_fail = 0;
  int                              samples_checked = 0;
  int                              cyc = 0;

  // ==========================================================================
  // Clock, cycle count since reset release, instances
  // ==========================================================================
  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) cyc <= reset ? 0 : cyc + 1;

  aid_diag_record i_dut (
    .core_clk          (core_clk),
    .reset             (reset),
    .diag_buf_overflow (diag_buf_overflow),
    .comm_error        (comm_error),
    .chan_status       (chan_status),
    .rd_req            (rd_req),
    .rd_valid          (rd_valid),
    .rd_data           (rd_data),
    .chan_led          (chan_led),
    .module_err_led    (module_err_led)
  );

  aid_reader_model i_rdr (
    .core_clk (core_clk),
    .rd_req   (rd_req),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  // ==========================================================================
  // Compare, read and closing tasks
  // ==========================================================================
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // A read must answer with a valid pulse as well as the byte
  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_rdr.read_byte(idx, 0, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask : rd_chk

  // Waits from one edge-plus-1ns point to another, so drives stay off the edge
  task automatic wait_cyc(input int n);
    while (cyc < n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : wait_cyc

  task automatic do_reset;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 reset = 1'b0;
  endtask : do_reset

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Record image right after reset, unmapped tail included
  function automatic logic [7:0] rst_img(input int i);
    case (i)
      1: return 8'h15;
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction : rst_img

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    #100000;
    n_fail++;
    $display("Watchdog expired at %0t ns", $time);
    conclude();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    logic [7:0]                      exp;
    aid_pkg::aid_chan_status_t [3:0] st;
    do_reset();
    for (int i = 0; i < 32; i++) rd_chk(5'(i), rst_img(i));
    check({3'h0, chan_led, module_err_led}, 8'h00);
    // Read data stands after the valid pulse is over
    rd_chk(5'd6, 8'h04);
    repeat (3) @(posedge core_clk);
    #1 check(rd_data, 8'h04);
    check({7'h00, rd_valid}, 8'h00);
    // Event in mid-microsecond 4, then in mid-microsecond 7
    wait_cyc(TICKS * 4 + 125);
    chan_status[2].underflow = 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(5'(16 + i), (i == 0) ? 8'h04 : 8'h00);
    chan_status = '0;
    wait_cyc(TICKS * 7 + 100);
    comm_error = 1'b1;
    rd_chk(5'd16, 8'h07);
    comm_error = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 rd_chk(5'd16, 8'h07);
    // Module flags alone and together
    for (int i = 1; i < 4; i++) begin
      diag_buf_overflow = i[0];
      comm_error = i[1];
      rd_chk(5'd3, {3'h0, i[1], i[0], 3'h0});
      check({7'h00, module_err_led}, 8'h01);
    end
    diag_buf_overflow = 1'b0;
    comm_error = 1'b0;
    // Every channel with every error kind; built aside so the inputs change once
    for (int ch = 0; ch < 4; ch++) begin
      for (int b = 0; b < 3; b++) begin
        st = '0;
        st[ch] = 3'(1 << b);
        chan_status = st;
        exp = (b == 0) ? 8'h01 : ((b == 1) ? 8'h40 : 8'h80);
        rd_chk(5'(8 + ch), exp);
        rd_chk(5'(8 + (ch + 1) % 4), 8'h00);
        rd_chk(5'd0, {(b == 0), 3'h0, 1'b1, 3'h0});
        rd_chk(5'd7, 8'(1 << ch));
        check({4'h0, chan_led}, 8'(1 << ch));
      end
    end
    chan_status = 12'hE00; // Channel 3 with all three errors
    rd_chk(5'd11, 8'hC1);
    chan_status = '0;
    rd_chk(5'd11, 8'h00);
    check({3'h0, chan_led, module_err_led}, 8'h00);
    // Second reset in mid-run clears record and timestamp
    diag_buf_overflow = 1'b1;
    rd_chk(5'd3, 8'h08);
    diag_buf_overflow = 1'b0;
    do_reset();
    rd_chk(5'd3, 8'h00);
    rd_chk(5'd16, 8'h00);
    conclude();
  end

endmodule : analog_input_diag_record_test

`default_nettype wire
